// file: hw/rbd_decoder.sv
// rom branch, table fetch and load instruction decoder for a 4-bit core
// Operation
// - long jump, branch, call load fourteen bits
// - memory is 64 pages of 256
// - page branch replaces low eight bits only
// - page branch at page end enters next
// - zero-page call targets 0x0000 to 0x003f
// - table branch from immediate, accumulator, b
// - table fetch bit8 loads accumulator and b
// - table fetch bit9 loads both port registers
// - both bits set update all four
// - table fetch leaves counter sequential
// - decoder covers the core's instruction groups
// - accumulator immediate load, one word cycle
// - b immediate load, one word cycle
// - store immediate, increment y, nonzero status
// - w moves take two words, operand zero
// - indirect ram address is w,x,y
// - memory registers at 0x040 to 0x04f
`timescale 1ns/1ns
`default_nettype none
module rbd_decoder #(
   parameter int PC_W = rbd_pkg::PC_W
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_instr_valid,
   input  wire logic [9:0]        i_instr,
   input  wire logic [9:0]        i_tbl_data,
   input  wire logic [3:0]        i_ram_rdata,
   output logic                   o_instr_ready,
   output logic      [PC_W-1:0]   o_pc,
   output logic      [PC_W-1:0]   o_tbl_addr,
   output logic      [9:0]        o_ram_addr,
   output logic      [3:0]        o_ram_wdata,
   output logic                   o_ram_we,
   output logic      [PC_W-1:0]   o_ret_addr,
   output logic                   o_ret_push,
   output logic      [3:0]        o_acc,
   output logic      [3:0]        o_breg,
   output logic      [1:0]        o_wreg,
   output logic      [3:0]        o_xreg,
   output logic      [3:0]        o_yreg,
   output logic                   o_status,
   output logic      [3:0]        o_port_out_lo,
   output logic      [3:0]        o_port_out_hi
);

   // table address built from immediate, b and accumulator
   function automatic logic [PC_W-1:0] tbl_addr(input logic [3:0] imm,
                                                input logic [3:0] b,
                                                input logic [3:0] a);
      tbl_addr = PC_W'({imm, b, a});
   endfunction

   // the page comes from the incremented counter, so a branch on a page's
   // last word lands in the following page
   function automatic logic [PC_W-1:0] page_tgt(input logic [PC_W-1:0] nxt,
                                                input logic [7:0]      imm);
      page_tgt = {nxt[PC_W-1:8], imm};
   endfunction

   // memory registers are a fixed sixteen-nibble window in ram
   function automatic logic [9:0] memreg_addr(input logic [3:0] m);
      memreg_addr = rbd_pkg::MEMREG_BASE | {6'h00, m};
   endfunction

   // sequencer, program counter and the architectural registers
   rbd_pkg::rbd_state_e st_r, st_nxt;
   logic [PC_W-1:0] pc_r, pc_nxt;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] taddr_r, taddr_nxt;
   logic [PC_W-1:0] ret_r, ret_nxt;
   logic            push_r, push_nxt;
   logic [9:0]      op1_r, op1_nxt;
   logic [9:0]      radr_r, radr_nxt;
   logic [3:0]      wdat_r, wdat_nxt;
   logic            we_r, we_nxt;
   logic [3:0]      acc_r, acc_nxt;
   logic [3:0]      breg_r, breg_nxt;
   logic [1:0]      wreg_r, wreg_nxt;
   logic [3:0]      xreg_r, xreg_nxt;
   logic [3:0]      yreg_r, yreg_nxt;
   logic [3:0]      y_inc;
   logic            stat_r, stat_nxt;
   logic [3:0]      plo_r, plo_nxt;
   logic [3:0]      phi_r, phi_nxt;
   logic            rdy_r, rdy_nxt;
   // six-bit prefix shared by most one-word decodes
   logic [5:0]      pfx;

   // sequential advance; upper bits carry across a page end
   assign pc_inc = pc_r + PC_W'(1);
   assign y_inc  = yreg_r + 4'h1;
   assign pfx    = i_instr[9:4];

   // decode, execute and next-state for the whole core slice
   always_comb begin
      // hold by default; the ram and return pulses fall unless raised
      st_nxt    = st_r;
      pc_nxt    = pc_r;
      taddr_nxt = taddr_r;
      ret_nxt   = ret_r;
      push_nxt  = 1'b0;
      op1_nxt   = op1_r;
      radr_nxt  = radr_r;
      wdat_nxt  = wdat_r;
      we_nxt    = 1'b0;
      acc_nxt   = acc_r;
      breg_nxt  = breg_r;
      wreg_nxt  = wreg_r;
      xreg_nxt  = xreg_r;
      yreg_nxt  = yreg_r;
      stat_nxt  = stat_r;
      plo_nxt   = plo_r;
      phi_nxt   = phi_r;
      case (st_r)
         rbd_pkg::ST_EXEC: begin
            if (i_instr_valid) begin
               pc_nxt = pc_inc;
               if (i_instr[9:8] == rbd_pkg::OP_PAGE_BRANCH) begin
                  pc_nxt = page_tgt(pc_inc, i_instr[7:0]);
               end else if (i_instr[9:6] == rbd_pkg::OP_ZERO_PAGE_CALL) begin
                  ret_nxt  = pc_inc;
                  push_nxt = 1'b1;
                  pc_nxt   = PC_W'(i_instr[5:0]);
               end else if (pfx == rbd_pkg::OP_LONG_JUMP ||
                            pfx == rbd_pkg::OP_LONG_BRANCH ||
                            pfx == rbd_pkg::OP_LONG_CALL ||
                            i_instr == rbd_pkg::OP_ACC_FROM_WREG ||
                            i_instr == rbd_pkg::OP_WREG_FROM_ACC) begin
                  // two-word ops finish on the operand word
                  op1_nxt = i_instr;
                  st_nxt  = rbd_pkg::ST_WORD2;
               end else if (pfx == rbd_pkg::OP_TABLE_BRANCH) begin
                  pc_nxt = tbl_addr(i_instr[3:0], breg_r, acc_r);
               end else if (pfx == rbd_pkg::OP_TABLE_FETCH) begin
                  taddr_nxt = tbl_addr(i_instr[3:0], breg_r, acc_r);
                  st_nxt    = rbd_pkg::ST_TABLE;
               end else if (pfx == rbd_pkg::OP_ACC_LOAD_IMM) begin
                  acc_nxt = i_instr[3:0];
               end else if (pfx == rbd_pkg::OP_BREG_LOAD_IMM) begin
                  breg_nxt = i_instr[3:0];
               // x and y immediates feed the indirect address
               end else if (pfx == rbd_pkg::OP_XREG_LOAD_IMM) begin
                  xreg_nxt = i_instr[3:0];
               end else if (pfx == rbd_pkg::OP_YREG_LOAD_IMM) begin
                  yreg_nxt = i_instr[3:0];
               // w immediate carries only two bits
               end else if (i_instr[9:2] == rbd_pkg::OP_WREG_LOAD_IMM) begin
                  wreg_nxt = i_instr[1:0];
               end else if (pfx == rbd_pkg::OP_MEM_STORE_INC) begin
                  radr_nxt = {wreg_r, xreg_r, yreg_r};
                  wdat_nxt = i_instr[3:0];
                  we_nxt   = 1'b1;
                  yreg_nxt = y_inc;
                  stat_nxt = (y_inc != 4'h0);
               end else if (pfx == rbd_pkg::OP_ACC_FROM_MEMREG ||
                            pfx == rbd_pkg::OP_MEMREG_SWAP) begin
                  // both stall one cycle for the ram read
                  radr_nxt = memreg_addr(i_instr[3:0]);
                  op1_nxt  = i_instr;
                  st_nxt   = rbd_pkg::ST_MEM;
               // register moves, one word each
               end else if (i_instr == rbd_pkg::OP_ACC_FROM_BREG) begin
                  acc_nxt = breg_r;
               end else if (i_instr == rbd_pkg::OP_BREG_FROM_ACC) begin
                  breg_nxt = acc_r;
               end else if (i_instr == rbd_pkg::OP_ACC_FROM_YREG) begin
                  acc_nxt = yreg_r;
               end else begin
                  pc_nxt = pc_inc;
               end
            end
         end
         rbd_pkg::ST_WORD2: begin
            // the operand word is taken whatever it would decode as
            if (i_instr_valid) begin
               pc_nxt = pc_inc;
               st_nxt = rbd_pkg::ST_EXEC;
               if (op1_r == rbd_pkg::OP_ACC_FROM_WREG) begin
                  acc_nxt = {2'b00, wreg_r};
               end else if (op1_r == rbd_pkg::OP_WREG_FROM_ACC) begin
                  wreg_nxt = acc_r[1:0];
               end else begin
                  pc_nxt = {op1_r[3:0], i_instr};
                  if (op1_r[9:4] == rbd_pkg::OP_LONG_CALL) begin
                     ret_nxt  = pc_inc;
                     push_nxt = 1'b1;
                  end
               end
            end
         end
         rbd_pkg::ST_TABLE: begin
            // no word is taken here: the table word needs this cycle
            st_nxt = rbd_pkg::ST_EXEC;
            // table data into a and b and into the ports
            if (i_tbl_data[rbd_pkg::TBL_ACC_BIT]) begin
               acc_nxt  = i_tbl_data[3:0];
               breg_nxt = i_tbl_data[7:4];
            end
            if (i_tbl_data[rbd_pkg::TBL_PORT_BIT]) begin
               plo_nxt = i_tbl_data[3:0];
               phi_nxt = i_tbl_data[7:4];
            end
         end
         rbd_pkg::ST_MEM: begin
            // combinational ram read, valid while the address stands
            st_nxt  = rbd_pkg::ST_EXEC;
            acc_nxt = i_ram_rdata;
            if (op1_r[9:4] == rbd_pkg::OP_MEMREG_SWAP) begin
               wdat_nxt = acc_r;
               we_nxt   = 1'b1;
            end
         end
         default: begin
            // unused state code; fall back to fetching
            st_nxt = rbd_pkg::ST_EXEC;
         end
      endcase
      // words are only taken in the fetch states
      rdy_nxt = (st_nxt == rbd_pkg::ST_EXEC) || (st_nxt == rbd_pkg::ST_WORD2);
   end

   // register every piece of state; constants only under reset
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r    <= rbd_pkg::ST_EXEC;
         pc_r    <= rbd_pkg::PC_RST;
         taddr_r <= rbd_pkg::PC_RST;
         ret_r   <= rbd_pkg::PC_RST;
         push_r  <= 1'b0;
         op1_r   <= rbd_pkg::ADR_RST;
         radr_r  <= rbd_pkg::ADR_RST;
         wdat_r  <= rbd_pkg::NIB_RST;
         we_r    <= 1'b0;
         acc_r   <= rbd_pkg::NIB_RST;
         breg_r  <= rbd_pkg::NIB_RST;
         wreg_r  <= rbd_pkg::W_RST;
         xreg_r  <= rbd_pkg::NIB_RST;
         yreg_r  <= rbd_pkg::NIB_RST;
         stat_r  <= 1'b0;
         plo_r   <= rbd_pkg::NIB_RST;
         phi_r   <= rbd_pkg::NIB_RST;
         rdy_r   <= 1'b1;
      end else begin
         st_r    <= st_nxt;
         pc_r    <= pc_nxt;
         taddr_r <= taddr_nxt;
         ret_r   <= ret_nxt;
         push_r  <= push_nxt;
         op1_r   <= op1_nxt;
         radr_r  <= radr_nxt;
         wdat_r  <= wdat_nxt;
         we_r    <= we_nxt;
         acc_r   <= acc_nxt;
         breg_r  <= breg_nxt;
         wreg_r  <= wreg_nxt;
         xreg_r  <= xreg_nxt;
         yreg_r  <= yreg_nxt;
         stat_r  <= stat_nxt;
         plo_r   <= plo_nxt;
         phi_r   <= phi_nxt;
         rdy_r   <= rdy_nxt;
      end
   end

   // outputs are plain flop copies so the fetch path sees no glitches
   assign o_instr_ready = rdy_r;
   assign o_pc          = pc_r;
   assign o_tbl_addr    = taddr_r;
   assign o_ram_addr    = radr_r;
   assign o_ram_wdata   = wdat_r;
   assign o_ram_we      = we_r;
   assign o_ret_addr    = ret_r;
   assign o_ret_push    = push_r;
   assign o_acc         = acc_r;
   assign o_breg        = breg_r;
   assign o_wreg        = wreg_r;
   assign o_xreg        = xreg_r;
   assign o_yreg        = yreg_r;
   assign o_status      = stat_r;
   assign o_port_out_lo = plo_r;
   assign o_port_out_hi = phi_r;

endmodule
`default_nettype wire

// file: common/rbd_pkg.sv
// constants and types shared by the rom branch and load decoder
package rbd_pkg;
   // widths of the core's datapath
   localparam int PC_W   = 14;
   localparam int PAGE_W = 8;
   localparam int WORD_W = 10;
   localparam int NIB_W  = 4;
   localparam int RAM_AW = 10;
   // values after reset
   localparam logic [13:0] PC_RST  = 14'h0000;
   localparam logic [3:0]  NIB_RST = 4'h0;
   localparam logic [1:0]  W_RST   = 2'h0;
   localparam logic [9:0]  ADR_RST = 10'h000;
   // six-bit opcode prefixes, four-bit operand below
   localparam logic [5:0] OP_ACC_LOAD_IMM    = 6'h23;
   localparam logic [5:0] OP_BREG_LOAD_IMM   = 6'h20;
   localparam logic [5:0] OP_XREG_LOAD_IMM   = 6'h22;
   localparam logic [5:0] OP_YREG_LOAD_IMM   = 6'h21;
   localparam logic [5:0] OP_MEM_STORE_INC   = 6'h29;
   localparam logic [5:0] OP_ACC_FROM_MEMREG = 6'h27;
   localparam logic [5:0] OP_MEMREG_SWAP     = 6'h2f;
   localparam logic [5:0] OP_LONG_JUMP       = 6'h16;
   localparam logic [5:0] OP_LONG_BRANCH     = 6'h17;
   localparam logic [5:0] OP_LONG_CALL       = 6'h14;
   localparam logic [5:0] OP_TABLE_BRANCH    = 6'h0b;
   localparam logic [5:0] OP_TABLE_FETCH     = 6'h1b;
   // other prefix widths: eight bits for the two-bit w immediate, shorter for wider immediates
   localparam logic [7:0] OP_WREG_LOAD_IMM   = 8'h3c;
   localparam logic [1:0] OP_PAGE_BRANCH     = 2'h3;
   localparam logic [3:0] OP_ZERO_PAGE_CALL  = 4'h7;
   // whole-word opcodes
   localparam logic [9:0] OP_ACC_FROM_WREG   = 10'h100;
   localparam logic [9:0] OP_WREG_FROM_ACC   = 10'h110;
   localparam logic [9:0] OP_ACC_FROM_BREG   = 10'h048;
   localparam logic [9:0] OP_BREG_FROM_ACC   = 10'h0c8;
   localparam logic [9:0] OP_ACC_FROM_YREG   = 10'h0af;
   // memory registers sit at a fixed ram window
   localparam logic [9:0] MEMREG_BASE        = 10'h040;
   // table word flag positions
   localparam int TBL_ACC_BIT  = 8;
   localparam int TBL_PORT_BIT = 9;
   // sequencer states
   typedef enum logic [1:0] {
      ST_EXEC,
      ST_WORD2,
      ST_TABLE,
      ST_MEM
   } rbd_state_e;
endpackage

// file: sim/rbd_decoder_sva.sv
// assertion checker for the rom branch and load decoder, with its bind
`timescale 1ns/1ns
`default_nettype none
module rbd_decoder_sva #(
   parameter int PC_W = 14
) (
   input wire logic            i_ref_clk,
   input wire logic            i_rst_b,
   input wire logic            i_instr_valid,
   input wire logic [9:0]      i_instr,
   input wire logic            o_instr_ready,
   input wire logic [PC_W-1:0] o_pc,
   input wire logic [9:0]      o_ram_addr,
   input wire logic            o_ram_we,
   input wire logic            o_ret_push,
   input wire logic [3:0]      o_acc,
   input wire logic [3:0]      o_breg,
   input wire logic [3:0]      o_xreg,
   input wire logic [3:0]      o_yreg,
   input wire logic [1:0]      o_wreg,
   input wire logic            o_status
);
   logic             sec_r;
   logic             long_r;
   logic [3:0]       hi_r;
   wire  logic       take = o_instr_ready && i_instr_valid;
   wire  logic       frst = take && !sec_r;
   wire  logic [5:0] op   = i_instr[9:4];
   wire  logic       lng  = op inside {rbd_pkg::OP_LONG_JUMP, rbd_pkg::OP_LONG_BRANCH, rbd_pkg::OP_LONG_CALL};
   // second words carry operands, so they must never be decoded as opcodes
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sec_r  <= 1'b0;
         long_r <= 1'b0;
         hi_r   <= 4'h0;
      end else if (take) begin
         sec_r  <= frst && (lng || i_instr == rbd_pkg::OP_ACC_FROM_WREG || i_instr == rbd_pkg::OP_WREG_FROM_ACC);
         long_r <= frst && lng;
         hi_r   <= i_instr[3:0];
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // table fetch: one refused cycle, counter moved by the fetch word only
   sequence s_tbl_stall;
      (!o_instr_ready && o_pc == $past(o_pc) + 1'b1) ##1 (o_instr_ready && $stable(o_pc));
   endsequence
   // swap: window address while stalled, then the write-back
   sequence s_swap;
      (!o_instr_ready && o_ram_addr == (rbd_pkg::MEMREG_BASE | $past(i_instr[3:0]))) ##1 (o_ram_we && o_instr_ready);
   endsequence
   chk_acc_imm: assert property (frst && op == rbd_pkg::OP_ACC_LOAD_IMM |=> o_acc == $past(i_instr[3:0]))
      else $error("accumulator immediate load wrong");
   chk_breg_imm: assert property (frst && op == rbd_pkg::OP_BREG_LOAD_IMM |=> o_breg == $past(i_instr[3:0]))
      else $error("b immediate load wrong");
   chk_long_target: assert property (take && long_r |=> o_pc == {$past(hi_r), $past(i_instr)})
      else $error("long target wrong");
   chk_page_branch: assert property (frst && i_instr[9:8] == rbd_pkg::OP_PAGE_BRANCH |=>
      o_pc == {$past(o_pc[PC_W-1:8]) + ($past(o_pc[7:0]) == 8'hff), $past(i_instr[7:0])})
      else $error("page branch target wrong");
   chk_zero_call: assert property (frst && i_instr[9:6] == rbd_pkg::OP_ZERO_PAGE_CALL |=>
      o_ret_push && o_pc == PC_W'($past(i_instr[5:0])))
      else $error("zero page call wrong");
   chk_push_cause: assert property (o_ret_push |-> $past(take))
      else $error("return push without a taken word");
   chk_table_stall: assert property (frst && op == rbd_pkg::OP_TABLE_FETCH |=> s_tbl_stall)
      else $error("table fetch sequencing wrong");
   chk_store_inc: assert property (frst && op == rbd_pkg::OP_MEM_STORE_INC |=> o_ram_we &&
      o_yreg == $past(o_yreg) + 4'h1 && o_status == (o_yreg != 4'h0) &&
      o_ram_addr == {$past(o_wreg), $past(o_xreg), $past(o_yreg)})
      else $error("store increment wrong");
   chk_memreg_swap: assert property (frst && op == rbd_pkg::OP_MEMREG_SWAP |=> s_swap)
      else $error("memory register swap wrong");
endmodule
bind rbd_decoder rbd_decoder_sva #(.PC_W(PC_W)) u_sva (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
   .o_instr_ready(o_instr_ready), .o_pc(o_pc), .o_ram_addr(o_ram_addr), .o_ram_we(o_ram_we),
   .o_ret_push(o_ret_push), .o_acc(o_acc), .o_breg(o_breg), .o_xreg(o_xreg), .o_yreg(o_yreg),
   .o_wreg(o_wreg), .o_status(o_status)
);
`default_nettype wire

// file: sim/rbd_decoder_bench.sv
// self-checking bench for the rom branch and load decoder
`timescale 1ns/1ns
`default_nettype none
module rbd_decoder_bench;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        i_instr_valid = 1'b0;
   logic [9:0]  i_instr = 10'h000;
   logic [9:0]  i_tbl_data = 10'h000;
   logic [3:0]  i_ram_rdata = 4'h0;
   logic        o_instr_ready, o_ram_we, o_ret_push, o_status;
   logic [13:0] o_pc, o_tbl_addr, o_ret_addr;
   logic [9:0]  o_ram_addr;
   logic [3:0]  o_ram_wdata, o_acc, o_breg, o_xreg, o_yreg, o_port_out_lo, o_port_out_hi;
   logic [1:0]  o_wreg;
   logic [5:0]  lop [3] = '{rbd_pkg::OP_LONG_JUMP, rbd_pkg::OP_LONG_BRANCH, rbd_pkg::OP_LONG_CALL};
   int          mismatches = 0;
   int          check_count = 0;
   // reference state of the core as plain integers
   int          pc = 0, a = 0, b = 0, w = 0, x = 0, y = 0, p = 0, d = 0, ra = 0, n, r, t;

   rbd_decoder u_dut (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_tbl_data(i_tbl_data), .i_ram_rdata(i_ram_rdata), .o_instr_ready(o_instr_ready), .o_pc(o_pc),
      .o_tbl_addr(o_tbl_addr), .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata), .o_ram_we(o_ram_we),
      .o_ret_addr(o_ret_addr), .o_ret_push(o_ret_push), .o_acc(o_acc), .o_breg(o_breg), .o_wreg(o_wreg),
      .o_xreg(o_xreg), .o_yreg(o_yreg), .o_status(o_status), .o_port_out_lo(o_port_out_lo),
      .o_port_out_hi(o_port_out_hi)
   );

   // 250 MHz reference clock
   initial begin
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input int exp);
      check_count++;
      if (seen !== 16'(exp)) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, 16'(exp), seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one word on a fresh falling edge; junk on i_instr while idle must be ignored
   task automatic issue(input logic [9:0] word);
      int k;
      k = 0;
      @(negedge i_ref_clk);
      i_instr_valid = 1'b1;
      i_instr = word;
      pc++;
      @(negedge i_ref_clk);
      i_instr_valid = 1'b0;
      i_instr = 10'($urandom);
      while (o_instr_ready !== 1'b1 && k < 8) begin
         @(negedge i_ref_clk);
         k++;
      end
      if (k == 8) begin
         mismatches++;
         results();
      end
   endtask

   // architectural state except status against the model
   task automatic state();
      check("pc", o_pc, pc);
      check("acc", o_acc, a);
      check("breg", o_breg, b);
      check("wreg", o_wreg, w);
      check("xreg", o_xreg, x);
      check("yreg", o_yreg, y);
      check("port", {o_port_out_hi, o_port_out_lo}, p);
   endtask

   // main sequence, all inputs change on the falling edge
   initial begin
      void'($urandom(32'h4a3b_7770));
      repeat (16) @(negedge i_ref_clk);
      i_rst_b = 1'b1;
      repeat (4) begin
         a = $urandom_range(15);
         b = $urandom_range(15);
         w = $urandom_range(3);
         issue({rbd_pkg::OP_ACC_LOAD_IMM, 4'(a)});
         issue({rbd_pkg::OP_BREG_LOAD_IMM, 4'(b)});
         issue({rbd_pkg::OP_WREG_LOAD_IMM, 2'(w)});
         state();
         issue(rbd_pkg::OP_ACC_FROM_WREG);
         issue(10'h000);
         a = w;
         issue(rbd_pkg::OP_BREG_FROM_ACC);
         b = a;
         a = $urandom_range(15);
         issue({rbd_pkg::OP_ACC_LOAD_IMM, 4'(a)});
         issue(rbd_pkg::OP_WREG_FROM_ACC);
         issue(10'h000);
         w = a % 4;
         state();
      end
      $display("test 1 done");
      // y of 15 wraps to zero and must clear status
      for (int i = 0; i < 3; i++) begin
         x = $urandom_range(15);
         y = i ? $urandom_range(15) : 15;
         n = $urandom_range(15);
         issue({rbd_pkg::OP_XREG_LOAD_IMM, 4'(x)});
         issue({rbd_pkg::OP_YREG_LOAD_IMM, 4'(y)});
         issue({rbd_pkg::OP_MEM_STORE_INC, 4'(n)});
         check("addr", o_ram_addr, w * 256 + x * 16 + y);
         check("wdata", o_ram_wdata, n);
         d = n;
         check("we", o_ram_we, 1);
         y = (y + 1) % 16;
         check("status", o_status, y != 0);
         state();
         issue(i ? rbd_pkg::OP_ACC_FROM_YREG : rbd_pkg::OP_ACC_FROM_BREG);
         a = i ? y : b;
         state();
      end
      $display("test 2 done");
      for (int i = 0; i < 2; i++) begin
         n = $urandom_range(15);
         r = $urandom_range(15);
         i_ram_rdata = 4'(r);
         issue({i ? rbd_pkg::OP_ACC_FROM_MEMREG : rbd_pkg::OP_MEMREG_SWAP, 4'(n)});
         check("addr", o_ram_addr, 64 + n);
         check("we", o_ram_we, !i);
         d = i ? d : a;
         check("wdata", o_ram_wdata, d);
         a = r;
         state();
      end
      $display("test 3 done");
      // random nibbles show which half lands in which register
      for (int i = 0; i < 4; i++) begin
         n = $urandom_range(15);
         r = $urandom_range(255);
         i_tbl_data = {2'(i), 8'(r)};
         issue({rbd_pkg::OP_TABLE_FETCH, 4'(n)});
         check("taddr", o_tbl_addr, n * 256 + b * 16 + a);
         a = i[0] ? r % 16 : a;
         b = i[0] ? r / 16 : b;
         p = i[1] ? r : p;
         state();
      end
      $display("test 4 done");
      for (int i = 0; i < 3; i++) begin
         t = $urandom_range(16383);
         issue({lop[i], 4'(t >> 10)});
         issue(10'(t));
         check("push", o_ret_push, i == 2);
         ra = i == 2 ? pc : ra;
         check("ret", o_ret_addr, ra);
         pc = t;
         state();
      end
      issue({rbd_pkg::OP_LONG_JUMP, 4'h0});
      issue(10'h0ff);
      pc = 255;
      repeat (2) begin
         r = $urandom_range(255);
         issue({rbd_pkg::OP_PAGE_BRANCH, 8'(r)});
         pc = (pc & 16'h3f00) | r;
         state();
      end
      // an unassigned word only advances the counter
      issue(10'h001);
      r = $urandom_range(63);
      issue({rbd_pkg::OP_ZERO_PAGE_CALL, 6'(r)});
      check("push", o_ret_push, 1);
      check("ret", o_ret_addr, pc);
      pc = r;
      state();
      n = $urandom_range(15);
      issue({rbd_pkg::OP_TABLE_BRANCH, 4'(n)});
      pc = n * 256 + b * 16 + a;
      state();
      $display("test 5 done");
      results();
   end
endmodule
`default_nettype wire
